/* File: hdl/can_msgbuf_consts.svh */
/*
 Offsets, field positions and reset values for the message buffer window block.
 Assumes byte-wide module-relative addressing over a 6-bit offset.
*/
`ifndef CAN_MSGBUF_CONSTS_SVH
`define CAN_MSGBUF_CONSTS_SVH

`define RX_WINDOW_BASE   6'h20
`define TX_WINDOW_BASE   6'h30
`define WINDOW_MASK      6'h30
`define BUF_IDX_W        4
`define BUF_BYTES        16
`define OFF_PRIORITY     4'hD
`define OFF_STAMP_HI     4'hE
`define OFF_STAMP_LO     4'hF
`define PRIORITY_RESET   8'h00
`define STAMP_RESET      16'h0000
`define NUM_TX_BUFS      3

`endif

/* File: hdl/can_msgbuf_pkg.sv */
/*
 Types shared by the message buffer window block.
 Assumes the constants header is included by users needing numbers.
*/
package can_msgbuf_pkg;
	typedef logic [7:0] byte_type;
	typedef logic [2:0] tx_sel_type;
endpackage

/* File: hdl/can_msgbuf_window.sv */
/*
 CPU-side access to the receive buffer window and the three transmit buffers
 shown one at a time through the transmit buffer window.
 Assumes a synchronous byte bus on clock_in; flags and receive data come from
 protocol logic on the same clock, so no synchronisers are used.
*/
`timescale 1ns/10ps
`include "can_msgbuf_consts.svh"
`default_nettype none

module can_msgbuf_window
	import can_msgbuf_pkg::*;
#(
	parameter int NUM_TX = `NUM_TX_BUFS
) (
	// clock, reset, enable
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	input  wire logic        clk_en_in,
	// cpu bus
	input  wire logic [5:0]  addr_in,
	input  wire logic        rd_in,
	input  wire logic        wr_in,
	input  wire logic [7:0]  wdata_in,
	output logic      [7:0]  rdata_out,
	// selection and flags
	input  wire logic [2:0]  tx_buffer_selection_reg_in,
	input  wire logic [2:0]  tx_buffer_empty_flag_in,
	input  wire logic        receive_full_flag_in,
	// receive side data and stamp capture
	input  wire logic [7:0]  rx_rdata_in,
	output logic      [3:0]  rx_addr_out,
	input  wire logic        stamp_wr_in,
	input  wire logic [1:0]  stamp_buf_in,
	input  wire logic [15:0] stamp_in,
	// transmit buffer view for the protocol engine
	input  wire logic [1:0]  eng_buf_in,
	input  wire logic [3:0]  eng_addr_in,
	output logic      [7:0]  eng_rdata_out
);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	byte_type    body_r  [NUM_TX][`OFF_PRIORITY];
	byte_type    prio_r  [NUM_TX];
	logic [15:0] stamp_r [NUM_TX];
	byte_type    win_byte;
	byte_type    eng_byte;
	tx_sel_type  low_sel;
	logic [1:0]  sel_idx;
	logic        rx_hit;
	logic        tx_hit;
	logic        tx_ok;
	logic        tx_wr;
	logic [3:0]  off;

	assign off    = addr_in[3:0];
	assign rx_hit = (addr_in & `WINDOW_MASK) == `RX_WINDOW_BASE;
	assign tx_hit = (addr_in & `WINDOW_MASK) == `TX_WINDOW_BASE;
	// isolate lowest set bit so only one buffer is ever mapped
	assign low_sel = tx_buffer_selection_reg_in & (~tx_buffer_selection_reg_in + 3'h1);
	always_comb begin
		sel_idx = 2'h0;
		case (low_sel)
			3'h1: sel_idx = 2'h0;
			3'h2: sel_idx = 2'h1;
			3'h4: sel_idx = 2'h2;
			default: sel_idx = 2'h0;
		endcase
	end
	// empty flag of the selected buffer gates both directions
	assign tx_ok = (low_sel != 3'h0) && tx_buffer_empty_flag_in[sel_idx];
	assign rx_addr_out = off;
	assign tx_wr = wr_in && tx_hit && tx_ok;

	// byte of the selected buffer at the window offset
	always_comb begin
		win_byte = 8'h00;
		case (off)
			`OFF_PRIORITY: win_byte = prio_r[sel_idx];
			`OFF_STAMP_HI: win_byte = stamp_r[sel_idx][15:8];
			`OFF_STAMP_LO: win_byte = stamp_r[sel_idx][7:0];
			default:       win_byte = body_r[sel_idx][off];
		endcase
	end

	// same view for the engine; a buffer index out of range is blocked at the register
	always_comb begin
		eng_byte = 8'h00;
		case (eng_addr_in)
			`OFF_PRIORITY: eng_byte = prio_r[eng_buf_in];
			`OFF_STAMP_HI: eng_byte = stamp_r[eng_buf_in][15:8];
			`OFF_STAMP_LO: eng_byte = stamp_r[eng_buf_in][7:0];
			default:       eng_byte = body_r[eng_buf_in][eng_addr_in];
		endcase
	end

	// ------------------------------------------------------------
	// transmit buffer storage
	// ------------------------------------------------------------
	// priority resets to zero instead of powering up unknown
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			for (int b = 0; b < NUM_TX; b++) begin
				prio_r[b] <= `PRIORITY_RESET;
			end
		end else if (clk_en_in) begin
			if (tx_wr && off == `OFF_PRIORITY) begin
				prio_r[sel_idx] <= wdata_in;
			end
		end
	end

	// identifier, data and length bytes; left unreset as in ram
	always_ff @(posedge clock_in) begin
		if (clk_en_in && tx_wr && off < `OFF_PRIORITY) begin
			body_r[sel_idx][off] <= wdata_in;
		end
	end

	// cpu has no write path here; only capture updates the stamps
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			for (int b = 0; b < NUM_TX; b++) begin
				stamp_r[b] <= `STAMP_RESET;
			end
		end else if (clk_en_in && stamp_wr_in && stamp_buf_in < 2'(NUM_TX)) begin
			stamp_r[stamp_buf_in] <= stamp_in;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= 8'h00;
		end else if (clk_en_in) begin
			if (rd_in && rx_hit && receive_full_flag_in) begin
				rdata_out <= rx_rdata_in;
			end else if (rd_in && tx_hit && tx_ok) begin
				rdata_out <= win_byte;
			end else if (rd_in) begin
				rdata_out <= 8'h00;
			end
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			eng_rdata_out <= 8'h00;
		end else if (clk_en_in && eng_buf_in < 2'(NUM_TX)) begin
			eng_rdata_out <= eng_byte;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_rx_gate;
		@(posedge clock_in) disable iff (rst_in)
		(clk_en_in && rd_in && rx_hit && !receive_full_flag_in) |=> rdata_out == 8'h00;
	endproperty
	a_rx_gate: assert property (p_rx_gate) else $error("rx read without full flag");

	property p_tx_gate;
		@(posedge clock_in) disable iff (rst_in)
		(clk_en_in && rd_in && tx_hit && !tx_ok) |=> rdata_out == 8'h00;
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("tx read while not allowed");

	property p_low_one;
		@(posedge clock_in) disable iff (rst_in)
		$onehot0(low_sel) && (tx_buffer_selection_reg_in[0] -> sel_idx == 2'h0);
	endproperty
	a_low_one: assert property (p_low_one) else $error("select not lowest");

	property p_prio_wr;
		@(posedge clock_in) disable iff (rst_in)
		(clk_en_in && tx_wr && off == `OFF_PRIORITY)
			|=> prio_r[$past(sel_idx)] == $past(wdata_in);
	endproperty
	a_prio_wr: assert property (p_prio_wr) else $error("priority write lost");

	property p_prio_rst;
		@(posedge clock_in) $fell(rst_in)
			|-> prio_r[0] == `PRIORITY_RESET && prio_r[NUM_TX-1] == `PRIORITY_RESET;
	endproperty
	a_prio_rst: assert property (p_prio_rst) else $error("priority not zero");

	property p_stamp_ro;
		@(posedge clock_in) disable iff (rst_in)
		(clk_en_in && !stamp_wr_in)
			|=> stamp_r[$past(sel_idx)] == $past(stamp_r[sel_idx]);
	endproperty
	a_stamp_ro: assert property (p_stamp_ro) else $error("stamp written by cpu");

	property p_sel_none;
		@(posedge clock_in) disable iff (rst_in)
		(tx_buffer_selection_reg_in == 3'h0) |-> !tx_ok;
	endproperty
	a_sel_none: assert property (p_sel_none) else $error("window open with no select");

	property p_decode;
		@(posedge clock_in) disable iff (rst_in)
		!(rx_hit && tx_hit);
	endproperty
	a_decode: assert property (p_decode) else $error("windows overlap");

	property p_rx_pass;
		@(posedge clock_in) disable iff (rst_in)
		(clk_en_in && rd_in && rx_hit && receive_full_flag_in)
			|=> rdata_out == $past(rx_rdata_in);
	endproperty
	a_rx_pass: assert property (p_rx_pass) else $error("rx byte not passed");

	property p_body_wr;
		@(posedge clock_in) disable iff (rst_in)
		(clk_en_in && tx_wr && off < `OFF_PRIORITY)
			|=> body_r[$past(sel_idx)][$past(off)] == $past(wdata_in);
	endproperty
	a_body_wr: assert property (p_body_wr) else $error("buffer write lost");

endmodule
`default_nettype wire

/* File: sim/cpu_host_model.sv */
/*
 Host cpu bus model for the message buffer window block.
 Assumes strobes are taken on the rising edge of clock_in.
*/
`timescale 1ns/10ps
`default_nettype none
module cpu_host_model (
	// bus
	input  wire logic       clock_in,
	output logic      [5:0] addr_out,
	output logic            rd_out,
	output logic            wr_out,
	output logic      [7:0] wdata_out
);
	initial begin
		addr_out = 6'h00;
		rd_out = 1'b0;
		wr_out = 1'b0;
		wdata_out = 8'h00;
	end
	task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(negedge clock_in);
		addr_out = a;
		wdata_out = d;
		rd_out = !w;
		wr_out = w;
		@(negedge clock_in);
		rd_out = 1'b0;
		wr_out = 1'b0;
		// released lines show the inverse, never stale values
		addr_out = ~a;
		wdata_out = ~d;
	endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
/*
 Self-checking bench for the message buffer window block.
 Assumes the host model drives the bus; flags are driven here.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import can_msgbuf_pkg::*;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	tx_sel_type sel = 3'h0;
	tx_sel_type empty = 3'h7;
	logic receive_full_flag = 1'b0;
	logic clk_en = 1'b1;
	logic stamp_wr = 1'b0;
	logic [1:0] stamp_buf = 2'h0;
	logic [15:0] stamp = 16'h0000;
	logic [1:0] eng_buf = 2'h2;
	logic [3:0] eng_addr = 4'h0;
	logic [3:0] rx_addr;
	logic [5:0] addr;
	logic rd;
	logic wr;
	byte_type wdata;
	byte_type rdata;
	byte_type eng_rdata;
	int mismatches = 0;
	int checked = 0;
	always #12.5 clock_in = ~clock_in;
	cpu_host_model i_cpu (.clock_in(clock_in), .addr_out(addr), .rd_out(rd), .wr_out(wr),
		.wdata_out(wdata));
	can_msgbuf_window i_dut (.clock_in(clock_in), .rst_in(rst_in), .clk_en_in(clk_en),
		.addr_in(addr), .rd_in(rd), .wr_in(wr), .wdata_in(wdata), .rdata_out(rdata),
		.tx_buffer_selection_reg_in(sel), .tx_buffer_empty_flag_in(empty),
		.receive_full_flag_in(receive_full_flag), .rx_rdata_in({4'hA, rx_addr}), .rx_addr_out(rx_addr),
		.stamp_wr_in(stamp_wr), .stamp_buf_in(stamp_buf), .stamp_in(stamp),
		.eng_buf_in(eng_buf), .eng_addr_in(eng_addr), .eng_rdata_out(eng_rdata));
	task automatic chk(input byte_type got, input byte_type exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [5:0] a, input byte_type exp);
		i_cpu.access(1'b0, a, 8'h00);
		chk(rdata, exp);
	endtask
	task automatic t_buffers;
		for (int i = 0; i < 3; i++) begin
			sel = 3'h1 << i;
			rdc(6'h3D, 8'h00);
			i_cpu.access(1'b1, 6'h30, 8'h10 + 8'(i));
		end
		for (int i = 0; i < 3; i++) begin
			sel = 3'h1 << i;
			rdc(6'h30, 8'h10 + 8'(i));
		end
		chk(eng_rdata, 8'h12);
		$display("test buffers done");
	endtask
	task automatic t_access;
		sel = 3'h6;
		rdc(6'h30, 8'h11);
		sel = 3'h0;
		rdc(6'h30, 8'h00);
		sel = 3'h1;
		empty = 3'h6;
		i_cpu.access(1'b1, 6'h30, 8'hFF);
		rdc(6'h30, 8'h00);
		empty = 3'h7;
		rdc(6'h30, 8'h10);
		clk_en = 1'b0;
		i_cpu.access(1'b1, 6'h3D, 8'h55);
		clk_en = 1'b1;
		rdc(6'h3D, 8'h00);
		i_cpu.access(1'b1, 6'h3D, 8'h55);
		rdc(6'h3D, 8'h55);
		$display("test access done");
	endtask
	task automatic t_stamp;
		for (int i = 0; i < 3; i++) begin
			@(negedge clock_in);
			stamp_buf = 2'(i);
			stamp = 16'h1200 + 16'(i);
			stamp_wr = 1'b1;
			@(negedge clock_in);
			stamp_wr = 1'b0;
		end
		for (int i = 0; i < 3; i++) begin
			sel = 3'h1 << i;
			i_cpu.access(1'b1, 6'h3E, 8'h77);
			rdc(6'h3E, 8'h12);
			rdc(6'h3F, 8'(i));
		end
		$display("test stamp done");
	endtask
	task automatic t_rx;
		receive_full_flag = 1'b1;
		rdc(6'h25, 8'hA5);
		i_cpu.access(1'b1, 6'h20, 8'h33);
		rdc(6'h30, 8'h12);
		receive_full_flag = 1'b0;
		rdc(6'h25, 8'h00);
		$display("test rx done");
	endtask
	task automatic complete_run;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clock_in);
		@(negedge clock_in);
		rst_in = 1'b0;
		t_buffers();
		t_access();
		t_stamp();
		t_rx();
		complete_run();
	end
	// tests need under a hundred cycles
	initial begin
		#100us;
		mismatches++;
		complete_run();
	end
endmodule
`default_nettype wire
